// *** rtl/caf_pkg.sv ***
// Notes on behaviour
// RULE_01 - compared standard bits must equal filter bits
// RULE_02 - compared extended bits must equal filter bits
// RULE_03 - sixteen filters, each with two registers
// RULE_04 - type match on: frame type equals select
// RULE_05 - type match off: either type passes
// RULE_06 - mask one compares bit, zero ignores it
// RULE_07 - select bit: one extended, zero standard
package caf_pkg;

    localparam int NUM_FILTERS = 16;                  // filters 0..15
    localparam int NUM_MASKS   = 2;                   // mask sets
    localparam int IDX_W       = 4;                   // filter index width

    // byte offsets on the register bus
    localparam logic [7:0] OFS_FILTER_BASE = 8'h00;   // filter n standard word at base + 8n
    localparam logic [7:0] OFS_FILTER_EXT  = 8'h04;   // filter n extended word at base + 8n + 4
    localparam logic [7:0] OFS_MASK_BASE   = 8'h80;   // mask m standard word at base + 8m
    localparam logic [7:0] OFS_MASK_SELECT = 8'h90;   // one mask-select bit per filter
    localparam logic [7:0] OFS_LAST_HITS   = 8'h94;   // hit vector of last message
    localparam logic [7:0] OFS_LAST_RESULT = 8'h98;   // hit flag, index, count

    // field positions in the standard-identifier registers
    localparam int STD_LSB     = 5;                   // standard bits [15:5]
    localparam int TYPE_BIT    = 3;                   // frame select / type match enable
    localparam int EXT_HI_LSB  = 0;                   // extended bits 17:16 at [1:0]
    localparam logic [15:0] STD_REG_WMASK = 16'hFFEB; // bits 4 and 2 read as zero

    // reset values of software registers
    localparam logic [15:0] RST_REG16    = 16'h0000;
    localparam logic [31:0] RST_WORD     = 32'h0000_0000;

    // one received identifier from the receive path
    typedef struct packed {
        logic        ext;                             // 1 = extended frame
        logic [17:0] ext_id;                          // extended identifier bits
        logic [10:0] std_id;                          // standard identifier bits
    } caf_msg_t;

    // one filter or mask: two 16-bit registers
    typedef struct packed {
        logic [15:0] ext_reg;                         // extended bits 15:0
        logic [15:0] std_reg;                         // standard bits, type bit, extended 17:16
    } caf_pair_t;

    // match outcome handed to the receive path
    typedef struct packed {
        logic                   hit;                  // any filter accepted
        logic [IDX_W-1:0]       index;                // lowest accepting filter
        logic [NUM_FILTERS-1:0] hits;                 // every accepting filter
    } caf_result_t;

endpackage : caf_pkg

// *** rtl/caf_filter_cmp.sv ***
`timescale 1ns/1ps
// one acceptance filter compared against one message, purely combinational
module caf_filter_cmp
    import caf_pkg::*;
(
    input  wire caf_pkg::caf_msg_t  i_msg,        // received identifier
    input  wire caf_pkg::caf_pair_t i_filter,     // filter registers
    input  wire caf_pkg::caf_pair_t i_mask,       // selected mask registers
    output logic                    o_hit         // message accepted
);
    import caf_pkg::*;

    logic [10:0] standard_id_bits;                // filter standard bits
    logic [17:0] extended_id_bits;                // filter extended bits
    logic [10:0] mask_std;                        // standard compare enables
    logic [17:0] mask_ext;                        // extended compare enables
    logic        extended_frame_select;           // filter frame type choice
    logic        frame_type_match_enable;         // mask type check enable
    logic        std_ok;                          // standard bits agree
    logic        ext_ok;                          // extended bits agree
    logic        type_ok;                         // frame type agrees

    // unpack register fields
    always_comb begin
        standard_id_bits        = i_filter.std_reg[15:STD_LSB];
        extended_id_bits        = {i_filter.std_reg[EXT_HI_LSB+1:EXT_HI_LSB], i_filter.ext_reg};
        mask_std                = i_mask.std_reg[15:STD_LSB];
        mask_ext                = {i_mask.std_reg[EXT_HI_LSB+1:EXT_HI_LSB], i_mask.ext_reg};
        extended_frame_select   = i_filter.std_reg[TYPE_BIT];
        frame_type_match_enable = i_mask.std_reg[TYPE_BIT];
    end

    // masked compare; a zero mask bit makes the position a don't-care
    always_comb begin
        std_ok = ((i_msg.std_id ^ standard_id_bits) & mask_std) == 11'h000; // RULE_01 RULE_06
        ext_ok = ((i_msg.ext_id ^ extended_id_bits) & mask_ext) == 18'h00000; // RULE_02 RULE_06
    end

    // frame type check only when the mask asks for it
    always_comb begin
        if (frame_type_match_enable) begin
            type_ok = (i_msg.ext == extended_frame_select); // RULE_04 RULE_07
        end else begin
            type_ok = 1'b1;                                  // RULE_05 RULE_07
        end
    end

    // standard frames carry no extended bits, so only standard bits take part
    always_comb begin
        o_hit = type_ok && std_ok && (i_msg.ext ? ext_ok : 1'b1); // RULE_05
    end

endmodule : caf_filter_cmp

// *** rtl/caf_match.sv ***
`timescale 1ns/1ps
// acceptance filter bank with apb register access
module caf_match
    import caf_pkg::*;
(
    input  wire logic               i_clk,          // 10 MHz system clock
    input  wire logic               i_reset_n,      // async reset, active low
    input  wire logic               i_ce,           // clock enable, freezes state
    input  wire logic               i_psel,         // apb select
    input  wire logic               i_penable,      // apb access phase
    input  wire logic               i_pwrite,       // apb write
    input  wire logic [7:0]         i_paddr,        // apb byte address
    input  wire logic [31:0]        i_pwdata,       // apb write data
    output logic [31:0]             o_prdata,       // apb read data
    output logic                    o_pready,       // apb ready
    output logic                    o_pslverr,      // apb error, unmapped address
    input  wire logic               i_msg_valid,    // identifier offered
    input  wire caf_pkg::caf_msg_t  i_msg,          // identifier from receive path
    output logic                    o_result_valid, // result pulse
    output caf_pkg::caf_result_t    o_result        // acceptance result
);
    import caf_pkg::*;

    // reset release synchroniser
    logic rst_meta_n;                              // first stage, read only by second
    logic rst_n;                                   // synchronised reset

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rst_meta_n <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_n      <= rst_meta_n;
        end
    end

    // register storage
    caf_pair_t                filters [NUM_FILTERS];  // per-filter standard and extended words
    caf_pair_t                masks   [NUM_MASKS];    // mask sets
    logic [NUM_FILTERS-1:0]   mask_select;            // which mask each filter uses
    logic [7:0]               accept_count;           // accepted messages, wraps

    // bus decode
    logic        wr_en;                            // write completes this edge
    logic        setup;                            // setup phase seen
    logic        addr_is_filter;                   // inside the filter window
    logic        addr_is_mask;                     // inside the mask window
    logic        addr_known;                       // address decodes to a register
    logic [3:0]  filter_idx;                       // filter number from address
    logic        mask_idx;                         // mask number from address
    logic        addr_is_ext;                      // second word of a pair
    logic [31:0] next_prdata;                      // read data for this address

    always_comb begin
        setup          = i_psel && !i_penable;
        wr_en          = i_psel && i_penable && o_pready && i_pwrite;
        filter_idx     = i_paddr[6:3];
        mask_idx       = i_paddr[3];
        addr_is_ext    = i_paddr[2];
        addr_is_filter = (i_paddr[7] == 1'b0) && (i_paddr[1:0] == 2'b00);
        addr_is_mask   = (i_paddr[7:4] == OFS_MASK_BASE[7:4]) && (i_paddr[1:0] == 2'b00);
        addr_known     = addr_is_filter || addr_is_mask
                         || (i_paddr == OFS_MASK_SELECT)
                         || (i_paddr == OFS_LAST_HITS)
                         || (i_paddr == OFS_LAST_RESULT);
    end

    // read mux; reserved bits come back as zero
    always_comb begin
        next_prdata = RST_WORD;
        if (addr_is_filter) begin
            next_prdata[15:0] = addr_is_ext ? filters[filter_idx].ext_reg
                                            : filters[filter_idx].std_reg;
        end else if (addr_is_mask) begin
            next_prdata[15:0] = addr_is_ext ? masks[mask_idx].ext_reg
                                            : masks[mask_idx].std_reg;
        end else if (i_paddr == OFS_MASK_SELECT) begin
            next_prdata[15:0] = mask_select;
        end else if (i_paddr == OFS_LAST_HITS) begin
            next_prdata[15:0] = o_result.hits;
        end else if (i_paddr == OFS_LAST_RESULT) begin
            next_prdata = {16'h0000, accept_count, 3'h0, o_result.hit, o_result.index};
        end
    end

    // apb answer: ready in the first access cycle, zero wait states
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_pready  <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata  <= RST_WORD;
        end else if (i_ce) begin
            o_pready <= setup;
            if (setup) begin
                o_pslverr <= !addr_known;           // unmapped: error, data zero
                o_prdata  <= (addr_known && !i_pwrite) ? next_prdata : RST_WORD;
            end else begin
                o_pslverr <= 1'b0;
                o_prdata  <= RST_WORD;
            end
        end
    end

    // filter registers; reset clears them to zero until software loads them
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int n = 0; n < NUM_FILTERS; n++) begin
                filters[n] <= '{ext_reg: RST_REG16, std_reg: RST_REG16};
            end
        end else if (i_ce && wr_en && addr_is_filter) begin
            if (addr_is_ext) begin
                filters[filter_idx].ext_reg <= i_pwdata[15:0];              // RULE_03
            end else begin
                filters[filter_idx].std_reg <= i_pwdata[15:0] & STD_REG_WMASK; // RULE_03
            end
        end
    end

    // mask registers and per-filter mask choice
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int m = 0; m < NUM_MASKS; m++) begin
                masks[m] <= '{ext_reg: RST_REG16, std_reg: RST_REG16};
            end
            mask_select <= RST_REG16;
        end else if (i_ce && wr_en) begin
            if (addr_is_mask) begin
                if (addr_is_ext) begin
                    masks[mask_idx].ext_reg <= i_pwdata[15:0];              // RULE_06
                end else begin
                    masks[mask_idx].std_reg <= i_pwdata[15:0] & STD_REG_WMASK; // RULE_06
                end
            end else if (i_paddr == OFS_MASK_SELECT) begin
                mask_select <= i_pwdata[15:0];
            end
        end
    end

    // sixteen independent comparators
    logic [NUM_FILTERS-1:0] hit_vec;               // combinational hits

    generate
        for (genvar g = 0; g < NUM_FILTERS; g++) begin : g_filter
            caf_filter_cmp u_cmp (                 // RULE_03
                .i_msg    (i_msg),
                .i_filter (filters[g]),
                .i_mask   (masks[mask_select[g]]),
                .o_hit    (hit_vec[g])
            );
        end
    endgenerate

    // lowest accepting filter wins the index
    logic [IDX_W-1:0] next_index;                  // priority encode of hit_vec

    always_comb begin
        next_index = '0;
        for (int n = NUM_FILTERS - 1; n >= 0; n--) begin
            if (hit_vec[n]) begin
                next_index = IDX_W'(n);
            end
        end
    end

    // result register, one cycle after the identifier is offered
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_result_valid <= 1'b0;
            o_result       <= '0;
        end else if (i_ce) begin
            o_result_valid <= i_msg_valid;
            if (i_msg_valid) begin
                o_result.hits  <= hit_vec;
                o_result.hit   <= |hit_vec;
                o_result.index <= next_index;
            end
        end
    end

    // count of accepted messages, visible to software
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            accept_count <= 8'h00;
        end else if (i_ce && i_msg_valid && (|hit_vec)) begin
            accept_count <= accept_count + 8'h01;
        end
    end

endmodule : caf_match

// *** verification/caf_match_asserts.sv ***
`timescale 1ns/1ps
// port-level checks: apb answer shape and result consistency
module caf_match_asserts
    import caf_pkg::*;
(
    input wire logic              i_clk,          // clock
    input wire logic              i_reset_n,      // reset, low
    input wire logic              i_ce,           // enable
    input wire logic              i_psel,         // select
    input wire logic              i_penable,      // access
    input wire logic              i_pwrite,       // write
    input wire logic [7:0]        i_paddr,        // address
    input wire logic [31:0]       i_pwdata,       // wdata
    input wire logic [31:0]       o_prdata,       // rdata
    input wire logic              o_pready,       // ready
    input wire logic              o_pslverr,      // error
    input wire logic              i_msg_valid,    // offer
    input wire caf_pkg::caf_msg_t i_msg,          // identifier
    input wire logic              o_result_valid, // result pulse
    input wire caf_pkg::caf_result_t o_result     // result
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    result_lat_a: assert property (o_result_valid == $past(i_msg_valid & i_ce))
        else $error("result pulse not one cycle after offer");
    ready_lat_a: assert property (o_pready == $past(i_psel & ~i_penable & i_ce))
        else $error("ready not one cycle after setup");
    ready_pulse_a: assert property (o_pready |=> !o_pready)
        else $error("ready longer than one cycle");
    err_ready_a: assert property (o_pslverr |-> o_pready && o_prdata == 32'h0000_0000)
        else $error("error without ready or with data");
    hit_any_a: assert property (o_result_valid |-> o_result.hit == (|o_result.hits))
        else $error("hit flag disagrees with hit vector");
    lowest_idx_a: assert property (o_result_valid && o_result.hit |->
        o_result.hits[o_result.index] && ((o_result.hits & ((16'h0001 << o_result.index)
        - 16'h0001)) == 16'h0000))
        else $error("index is not the lowest hit");
    result_hold_a: assert property (!o_result_valid |-> $stable(o_result))
        else $error("result changed without a pulse");
    idle_ready_a: assert property (!i_psel [*2] |-> !o_pready)
        else $error("ready without a transfer");
endmodule : caf_match_asserts

// *** verification/caf_rx_model.sv ***
`timescale 1ns/1ps
// receive path stand-in: one identifier per single-cycle pulse
module caf_rx_model
    import caf_pkg::*;
(
    input  wire logic         i_clk,       // clock
    output logic              o_msg_valid, // offer
    output caf_pkg::caf_msg_t o_msg        // identifier
);
    initial begin
        o_msg_valid = 1'b0;
        o_msg       = '0;
    end
    // fields are scrambled after the pulse so nothing leans on stale values
    task automatic offer(input caf_msg_t m);
        @(posedge i_clk);
        o_msg_valid <= 1'b1;
        o_msg       <= m;
        @(posedge i_clk);
        o_msg_valid <= 1'b0;
        o_msg       <= ~m;
    endtask : offer
endmodule : caf_rx_model

// *** verification/caf_match_tb.sv ***
`timescale 1ns/1ps
// register and match sequences against the filter bank
module caf_match_tb;
    import caf_pkg::*;
    logic        clk, reset_n, psel, penable, pwrite, pready, pslverr, mv, rv;
    logic [7:0]  paddr;        // byte address
    logic [31:0] pwdata, prdata, rdata;
    logic        rerr;         // last error flag
    caf_msg_t    msg;          // offered identifier
    caf_result_t res;          // match outcome
    int          fails, compares;
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    caf_match DUT (.i_clk(clk), .i_reset_n(reset_n), .i_ce(1'b1), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_msg_valid(mv),
        .i_msg(msg), .o_result_valid(rv), .o_result(res));
    caf_rx_model rx (.i_clk(clk), .o_msg_valid(mv), .o_msg(msg));
    // standard-word register image
    function automatic logic [31:0] sr(input logic [10:0] s, input logic t, input logic [1:0] e);
        return 32'({s, 1'b0, t, 1'b0, e});
    endfunction : sr
    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk32
    // one transfer; only the watchdog ends a wait on ready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        // request stands until pready is seen high at a rising edge
        do @(posedge clk); while (pready !== 1'b1);
        rdata   = prdata;
        rerr    = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // offer one identifier and compare pulse plus outcome
    task automatic send(input logic e, input logic [10:0] s, input logic [17:0] x,
                        input logic [15:0] h);
        caf_result_t exp;
        exp      = '0;
        exp.hits = h;
        exp.hit  = |h;
        for (int i = 15; i >= 0; i--) if (h[i]) exp.index = 4'(i);
        rx.offer(caf_msg_t'{ext: e, ext_id: x, std_id: s});
        #1;
        chk32(32'({rv, res}), 32'({1'b1, exp}));
    endtask : send
    task automatic report_and_stop();
        $display("TB: %0d compares, %0d fails", compares, fails);
        if (fails == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : report_and_stop
    initial begin
        repeat (4000) @(posedge clk);
        fails++;
        report_and_stop();
    end
    initial begin
        {reset_n, psel, penable, pwrite, paddr, pwdata, fails, compares} = '0;
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk);
        apb(0, 8'h08, 0);
        chk32(rdata, RST_WORD);
        apb(1, 8'h28, 32'hFFFF_FFFF);
        apb(0, 8'h28, 0);
        chk32(rdata, {16'h0000, STD_REG_WMASK});
        apb(1, 8'h2C, 32'hFFFF_1234);
        apb(0, 8'h2C, 0);
        chk32(rdata, 32'h0000_1234);
        apb(0, 8'hA0, 0);
        chk32({rerr, rdata[30:0]}, 32'h8000_0000);
        $display("test registers done");
        apb(1, 8'h80, sr(11'h7FF, 0, 2'b11));
        apb(1, 8'h84, 32'h0000_FFFF);
        apb(1, 8'h00, sr(11'h123, 0, 2'b10));
        apb(1, 8'h04, 32'h0000_BEEF);
        send(0, 11'h123, 18'h0, 16'h0001);
        send(0, 11'h122, 18'h0, 16'h0000);
        send(1, 11'h123, 18'h2BEEF, 16'h0001);
        send(1, 11'h123, 18'h2BEEE, 16'h0000);
        send(1, 11'h123, 18'h3BEEF, 16'h0000);
        $display("test compare done");
        apb(1, 8'h80, sr(11'h7FF, 1, 2'b11));
        apb(1, 8'h00, sr(11'h123, 1, 2'b10));
        send(1, 11'h123, 18'h2BEEF, 16'h0001);
        send(0, 11'h123, 18'h0, 16'h0000);
        apb(1, 8'h00, sr(11'h123, 0, 2'b10));
        send(0, 11'h123, 18'h0, 16'h0001);
        send(1, 11'h123, 18'h2BEEF, 16'h0000);
        $display("test frame type done");
        apb(1, 8'h80, sr(11'h7FE, 0, 2'b11));
        send(0, 11'h122, 18'h0, 16'h0001);
        send(1, 11'h123, 18'h2BEEF, 16'h0001);
        apb(1, 8'h78, sr(11'h7FF, 0, 2'b00));
        send(0, 11'h7FF, 18'h0, 16'h8020);
        $display("test masks and bank done");
        apb(1, 8'h88, sr(11'h000, 0, 2'b00));
        apb(1, 8'h90, 32'h0000_8000);
        apb(0, 8'h90, 0);
        chk32(rdata, 32'h0000_8000);
        send(0, 11'h400, 18'h0, 16'h8000);
        apb(0, 8'h94, 0);
        chk32(rdata, 32'h0000_8000);
        apb(0, 8'h98, 0);
        chk32(rdata, 32'h0000_081F);
        $display("test mask select and status done");
        report_and_stop();
    end
endmodule : caf_match_tb
bind caf_match caf_match_asserts u_chk (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_ce(i_ce),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .i_msg_valid(i_msg_valid), .i_msg(i_msg), .o_result_valid(o_result_valid),
    .o_result(o_result));
